// ===== bench/tb_raw_status_mask_irq.sv
// self-checking bench for the infoframe raw, status, mask and clear bits
`timescale 1ns/1ps
`default_nettype none
module tb_raw_status_mask_irq;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    // bit 0 frame seen, 1 changed content, 2 packet reset, 3 type write
    logic [3:0] ev = 4'h0;
    logic vs = 1'b0;
    logic [7:0] rdata;
    logic pin_a;
    logic pin_b;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    infoframe_irq i_dut (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .reg_addr_in(addr),
        .reg_wdata_in(wdata),
        .reg_wr_in(wr),
        .reg_rd_in(rd),
        .frame_rx_in(ev[0]),
        .frame_new_in(ev[1]),
        .pkt_reset_in(ev[2]),
        .pkt_type_wr_in(ev[3]),
        .vsync_in(vs),
        .reg_rdata_out(rdata),
        .irq_pin_a_out(pin_a),
        .irq_pin_b_out(pin_b)
    );
    initial begin
        forever #2 mclk_in = ~mclk_in;
    end
    // whole run needs well under a thousand cycles; this ceiling only cuts a hang
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if ((mismatches == 0) && (tests_run > 0)) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_in);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [7:0] e);
        @(posedge mclk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_in);
        rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge mclk_in);
        ev <= m;
        @(posedge mclk_in);
        ev <= 4'h0;
        #1;
    endtask
    // d below zero skips the rise-delay check (vsync path is synchronised)
    task automatic width(input string nm, input logic b, input int e,
                         input int d);
        int n;
        int w;
        n = 0;
        w = 0;
        while (((b ? pin_b : pin_a) !== 1'b1) && (w < 30)) begin
            tick(1);
            w++;
        end
        if (d >= 0) chk(nm, d[7:0], w[7:0]);
        while (((b ? pin_b : pin_a) === 1'b1) && (n < 200)) begin
            tick(1);
            n++;
        end
        chk(nm, e[7:0], n[7:0]);
    endtask
    task automatic quiet(input string nm, input int n);
        repeat (n) begin
            tick(1);
            chk(nm, 8'h00, {6'h00, pin_b, pin_a});
        end
    endtask
    task automatic t_reset();
        logic [7:0] al[12] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h79,
                               8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h40, 8'h55};
        foreach (al[i]) rd_chk("reset value", al[i], 8'h00);
        wr_reg(8'h60, 8'hff);
        wr_reg(8'h61, 8'hff);
        wr_reg(8'h79, 8'hff);
        wr_reg(8'h7a, 8'hff);
        rd_chk("ro present raw", 8'h60, 8'h00);
        rd_chk("ro changed st", 8'h7a, 8'h00);
        pulse(4'h2);
        quiet("unmasked pins", 6);
        rd_chk("unmasked raw", 8'h79, 8'h01);
        rd_chk("unmasked st", 8'h7a, 8'h00);
        wr_reg(8'h7b, 8'h01);
        wr_reg(8'h7c, 8'h01);
        rd_chk("chg mask b", 8'h7c, 8'h01);
        pulse(4'h2);
        width("chg pin b", 1'b1, evt_irq_pkg::LEN_4_CYC, 1);
        chk("chg pin a off", 8'h00, {7'h00, pin_a});
        wr_reg(8'h7c, 8'h00);
        wr_reg(8'h7b, 8'h01);
    endtask
    task automatic t_changed();
        wr_reg(evt_irq_pkg::ADDR_CHG_MASK_A, 8'h01);
        pulse(4'h2);
        width("chg pin a", 1'b0, evt_irq_pkg::LEN_4_CYC, 1);
        rd_chk("chg raw", 8'h79, 8'h01);
        rd_chk("chg st", 8'h7a, 8'h01);
        pulse(4'h2);
        quiet("second event", 10);
        wr_reg(8'h7b, 8'h00);
        rd_chk("chg clr zero", 8'h79, 8'h01);
        wr_reg(8'h7b, 8'h01);
        rd_chk("chg raw clr", 8'h79, 8'h00);
        rd_chk("chg st clr", 8'h7a, 8'h00);
        rd_chk("chg clr self", 8'h7b, 8'h00);
        pulse(4'h2);
        width("chg rearm", 1'b0, evt_irq_pkg::LEN_4_CYC, 1);
        // event in the same cycle as a clear must survive
        @(posedge mclk_in);
        addr <= 8'h7b;
        wdata <= 8'h01;
        wr <= 1'b1;
        ev <= 4'h2;
        @(posedge mclk_in);
        wr <= 1'b0;
        ev <= 4'h0;
        tick(2);
        rd_chk("coincide st", 8'h7a, 8'h01);
        wr_reg(8'h7b, 8'h01);
    endtask
    task automatic t_len();
        int e[3] = '{evt_irq_pkg::LEN_4_CYC, evt_irq_pkg::LEN_16_CYC,
                     evt_irq_pkg::LEN_64_CYC};
        for (int i = 0; i < 3; i++) begin
            wr_reg(8'h40, {i[1:0], 6'h00});
            wr_reg(8'h7b, 8'h01);
            pulse(4'h2);
            width("len sel", 1'b0, e[i], 1);
        end
        wr_reg(8'h40, 8'hc0);
        wr_reg(8'h7b, 8'h01);
        pulse(4'h2);
        tick(100);
        chk("hold mode", 8'h01, {7'h00, pin_a});
        wr_reg(8'h7b, 8'h01);
        tick(2);
        chk("hold cleared", 8'h00, {7'h00, pin_a});
        wr_reg(8'h7d, 8'h00);
        // back to the four-period default for the later pin a checks
        wr_reg(8'h40, 8'h00);
    endtask
    task automatic t_present();
        pulse(4'h1);
        rd_chk("pres raw", 8'h60, 8'h01);
        rd_chk("pres st off", 8'h61, 8'h00);
        wr_reg(8'h63, 8'h01);
        wr_reg(8'h41, 8'h80);
        for (int i = 1; i <= 8; i++) begin
            @(posedge mclk_in);
            vs <= 1'b1;
            tick(3);
            @(posedge mclk_in);
            vs <= 1'b0;
            tick(3);
            if (i == 7) rd_chk("pres after 7", 8'h60, 8'h01);
        end
        rd_chk("pres after 8", 8'h60, 8'h00);
        rd_chk("pres st drop", 8'h61, 8'h01);
        wr_reg(8'h62, 8'h01);
        rd_chk("pres st clr", 8'h61, 8'h00);
        tick(80);
        pulse(4'h1);
        width("pres pin b", 1'b1, evt_irq_pkg::LEN_64_CYC, 1);
        wr_reg(8'h62, 8'h00);
        rd_chk("pres clr zero", 8'h61, 8'h01);
        pulse(4'h4);
        rd_chk("pkt reset", 8'h60, 8'h00);
        pulse(4'h1);
        pulse(4'h8);
        rd_chk("type write", 8'h60, 8'h00);
        wr_reg(8'h62, 8'h01);
        rd_chk("pres clr", 8'h61, 8'h00);
        wr_reg(8'h63, 8'h00);
        wr_reg(8'h64, 8'h01);
        pulse(4'h1);
        width("pres pin a", 1'b0, evt_irq_pkg::LEN_4_CYC, 1);
    endtask
    initial begin
        repeat (8) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        tick(1);
        t_reset();
        t_changed();
        t_len();
        t_present();
        close_out();
    end
endmodule
`default_nettype wire

// ===== rtl/evt_irq_pkg.sv
// constants and types shared by the infoframe interrupt event logic
`default_nettype none
package evt_irq_pkg;
    localparam logic [7:0] ADDR_PIN_A_CFG = 8'h40;
    localparam logic [7:0] ADDR_PIN_B_CFG = 8'h41;
    localparam logic [7:0] ADDR_PRES_RAW = 8'h60;
    localparam logic [7:0] ADDR_PRES_ST = 8'h61;
    localparam logic [7:0] ADDR_PRES_CLR = 8'h62;
    localparam logic [7:0] ADDR_PRES_MASK_B = 8'h63;
    localparam logic [7:0] ADDR_PRES_MASK_A = 8'h64;
    localparam logic [7:0] ADDR_CHG_RAW = 8'h79;
    localparam logic [7:0] ADDR_CHG_ST = 8'h7a;
    localparam logic [7:0] ADDR_CHG_CLR = 8'h7b;
    localparam logic [7:0] ADDR_CHG_MASK_B = 8'h7c;
    localparam logic [7:0] ADDR_CHG_MASK_A = 8'h7d;
    localparam int FLAG_BIT = 0;
    localparam int LEN_HI = 7;
    localparam int LEN_LO = 6;
    localparam logic [7:0] RDATA_IDLE = 8'h00;
    typedef enum logic [1:0] {
        LEN_4 = 2'h0,
        LEN_16 = 2'h1,
        LEN_64 = 2'h2,
        LEN_HOLD = 2'h3
    } irq_len_t;
    localparam irq_len_t LEN_RESET = LEN_4;
    // pin lengths are given in crystal periods; mclk is the crystal
    localparam int CLK_PER_XTAL = 1;
    localparam int LEN_4_XTAL = 4;
    localparam int LEN_16_XTAL = 16;
    localparam int LEN_64_XTAL = 64;
    localparam int LEN_4_CYC = LEN_4_XTAL * CLK_PER_XTAL;
    localparam int LEN_16_CYC = LEN_16_XTAL * CLK_PER_XTAL;
    localparam int LEN_64_CYC = LEN_64_XTAL * CLK_PER_XTAL;
    localparam int LEN_CNT_W = 6;
    // vsyncs tolerated without an infoframe before presence drops
    localparam logic [2:0] VSYNC_LIMIT = 3'h7;
    localparam logic [2:0] VSYNC_CNT_ZERO = 3'h0;
    localparam logic [2:0] VSYNC_CNT_STEP = 3'h1;
    typedef enum logic [2:0] {
        PIN_IDLE = 3'b001,
        PIN_ACTIVE = 3'b010,
        PIN_DONE = 3'b100
    } pin_state_t;
endpackage
`default_nettype wire

// ===== rtl/evt_status.sv
// latched status bit of one event with its two pin requests
`timescale 1ns/1ps
`default_nettype none
module evt_status (
    input wire logic mclk_in,     // crystal clock
    input wire logic rst_n_in,    // sync reset, active low
    input wire logic change_in,   // raw bit changed state
    input wire logic clr_in,      // clear pulse
    input wire logic mask_a_in,   // route to pin a
    input wire logic mask_b_in,   // route to pin b
    output logic status_out,      // latched status
    output logic req_a_out,       // status routed to pin a
    output logic req_b_out        // status routed to pin b
);
    logic status_r;
    logic status_nxt;

    always_comb begin
        // a change in the clear cycle still sets: no event is lost
        status_nxt = (status_r & ~clr_in) |
            (change_in & (mask_a_in | mask_b_in));
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            status_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
        end
    end

    assign status_out = status_r;
    assign req_a_out = status_r & mask_a_in;
    assign req_b_out = status_r & mask_b_in;

    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    a_status_sticky: assert property (
        status_r && !clr_in |=> status_r)
        else $error("status dropped without clear");
    a_status_gated: assert property (
        $rose(status_r) |-> $past(mask_a_in || mask_b_in))
        else $error("status set while both masks off");
endmodule
`default_nettype wire

// ===== rtl/infoframe_irq.sv
// raw, status, mask and clear bits of the two infoframe events
`timescale 1ns/1ps
`default_nettype none
module infoframe_irq (
    input wire logic mclk_in,            // crystal clock, 250 MHz
    input wire logic rst_n_in,           // sync reset, active low
    input wire logic [7:0] reg_addr_in,  // register address
    input wire logic [7:0] reg_wdata_in, // register write data
    input wire logic reg_wr_in,          // write strobe, one cycle
    input wire logic reg_rd_in,          // read strobe, one cycle
    input wire logic frame_rx_in,        // infoframe received pulse
    input wire logic frame_new_in,       // changed content pulse
    input wire logic pkt_reset_in,       // packet detection reset
    input wire logic pkt_type_wr_in,     // packet type reg written
    input wire logic vsync_in,           // vsync pin, asynchronous
    output logic [7:0] reg_rdata_out,    // read data, next cycle
    output logic irq_pin_a_out,          // first interrupt pin
    output logic irq_pin_b_out           // second interrupt pin
);
    logic vs_s1_r;
    logic vs_s2_r;
    logic vs_prev_r;
    logic vs_edge;

    logic pres_raw_r;
    logic pres_raw_nxt;
    logic [2:0] vs_cnt_r;
    logic [2:0] vs_cnt_nxt;
    logic chg_raw_r;
    logic chg_raw_nxt;

    logic pres_mask_a_r;
    logic pres_mask_a_nxt;
    logic pres_mask_b_r;
    logic pres_mask_b_nxt;
    logic chg_mask_a_r;
    logic chg_mask_a_nxt;
    logic chg_mask_b_r;
    logic chg_mask_b_nxt;
    logic [1:0] len_a_r;
    logic [1:0] len_a_nxt;
    logic [1:0] len_b_r;
    logic [1:0] len_b_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    logic pres_clr;
    logic chg_clr;
    logic pres_chg;
    logic chg_chg;
    logic pres_st;
    logic chg_st;
    logic pres_req_a;
    logic pres_req_b;
    logic chg_req_a;
    logic chg_req_b;
    logic agg_a;
    logic agg_b;
    logic wdata_flag;
    logic pres_quiet;

    // vsync pin is asynchronous: two flops before any logic reads it
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            vs_s1_r <= 1'b0;
            vs_s2_r <= 1'b0;
            vs_prev_r <= 1'b0;
        end else begin
            vs_s1_r <= vsync_in;
            vs_s2_r <= vs_s1_r;
            vs_prev_r <= vs_s2_r;
        end
    end

    assign vs_edge = vs_s2_r & ~vs_prev_r;

    // clear bits are strobes only; they never store and read back 0
    assign wdata_flag = reg_wdata_in[evt_irq_pkg::FLAG_BIT];
    assign pres_clr = reg_wr_in && wdata_flag &&
        reg_addr_in == evt_irq_pkg::ADDR_PRES_CLR;
    assign chg_clr = reg_wr_in && wdata_flag &&
        reg_addr_in == evt_irq_pkg::ADDR_CHG_CLR;

    // presence raw: level type, follows live reception of infoframes
    always_comb begin
        pres_raw_nxt = pres_raw_r;
        vs_cnt_nxt = vs_cnt_r;
        if (frame_rx_in) begin
            pres_raw_nxt = 1'b1;
            vs_cnt_nxt = evt_irq_pkg::VSYNC_CNT_ZERO;
        end else if (pkt_reset_in || pkt_type_wr_in || pres_clr) begin
            pres_raw_nxt = 1'b0;
            vs_cnt_nxt = evt_irq_pkg::VSYNC_CNT_ZERO;
        end else if (vs_edge && pres_raw_r) begin
            if (vs_cnt_r == evt_irq_pkg::VSYNC_LIMIT) begin
                pres_raw_nxt = 1'b0;
                vs_cnt_nxt = evt_irq_pkg::VSYNC_CNT_ZERO;
            end else begin
                vs_cnt_nxt = vs_cnt_r + evt_irq_pkg::VSYNC_CNT_STEP;
            end
        end
    end

    // changed raw: edge type, latched until its clear; set wins
    always_comb begin
        chg_raw_nxt = (chg_raw_r & ~chg_clr) | frame_new_in;
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            pres_raw_r <= 1'b0;
            vs_cnt_r <= evt_irq_pkg::VSYNC_CNT_ZERO;
            chg_raw_r <= 1'b0;
        end else begin
            pres_raw_r <= pres_raw_nxt;
            vs_cnt_r <= vs_cnt_nxt;
            chg_raw_r <= chg_raw_nxt;
        end
    end

    // a drop caused by the clear itself must not re-arm the status, but
    // an event landing in the clear cycle is new and must set it
    assign pres_chg = pres_clr ? pres_raw_nxt :
        (pres_raw_nxt != pres_raw_r);
    assign chg_chg = chg_clr ? chg_raw_nxt :
        (chg_raw_nxt != chg_raw_r);

    evt_status u_pres_status (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .change_in(pres_chg),
        .clr_in(pres_clr),
        .mask_a_in(pres_mask_a_r),
        .mask_b_in(pres_mask_b_r),
        .status_out(pres_st),
        .req_a_out(pres_req_a),
        .req_b_out(pres_req_b)
    );

    evt_status u_chg_status (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .change_in(chg_chg),
        .clr_in(chg_clr),
        .mask_a_in(chg_mask_a_r),
        .mask_b_in(chg_mask_b_r),
        .status_out(chg_st),
        .req_a_out(chg_req_a),
        .req_b_out(chg_req_b)
    );

    assign agg_a = pres_req_a | chg_req_a;
    assign agg_b = pres_req_b | chg_req_b;

    irq_pin_pulse u_pin_a (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .agg_in(agg_a),
        .len_sel_in(len_a_r),
        .pin_out(irq_pin_a_out)
    );

    irq_pin_pulse u_pin_b (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .agg_in(agg_b),
        .len_sel_in(len_b_r),
        .pin_out(irq_pin_b_out)
    );

    // register writes; raw and status addresses ignore writes
    always_comb begin
        pres_mask_a_nxt = pres_mask_a_r;
        pres_mask_b_nxt = pres_mask_b_r;
        chg_mask_a_nxt = chg_mask_a_r;
        chg_mask_b_nxt = chg_mask_b_r;
        len_a_nxt = len_a_r;
        len_b_nxt = len_b_r;
        if (!reg_wr_in) begin
            len_a_nxt = len_a_r;
        end else if (reg_addr_in == evt_irq_pkg::ADDR_PRES_MASK_A) begin
            pres_mask_a_nxt = wdata_flag;
        end else if (reg_addr_in == evt_irq_pkg::ADDR_PRES_MASK_B) begin
            pres_mask_b_nxt = wdata_flag;
        end else if (reg_addr_in == evt_irq_pkg::ADDR_CHG_MASK_A) begin
            chg_mask_a_nxt = wdata_flag;
        end else if (reg_addr_in == evt_irq_pkg::ADDR_CHG_MASK_B) begin
            chg_mask_b_nxt = wdata_flag;
        end else if (reg_addr_in == evt_irq_pkg::ADDR_PIN_A_CFG) begin
            len_a_nxt = reg_wdata_in[evt_irq_pkg::LEN_HI:
                evt_irq_pkg::LEN_LO];
        end else if (reg_addr_in == evt_irq_pkg::ADDR_PIN_B_CFG) begin
            len_b_nxt = reg_wdata_in[evt_irq_pkg::LEN_HI:
                evt_irq_pkg::LEN_LO];
        end
    end

    // register reads; unmapped and write-only addresses read 0
    always_comb begin
        rdata_nxt = evt_irq_pkg::RDATA_IDLE;
        if (!reg_rd_in) begin
            rdata_nxt = evt_irq_pkg::RDATA_IDLE;
        end else if (reg_addr_in == evt_irq_pkg::ADDR_PRES_RAW) begin
            rdata_nxt[evt_irq_pkg::FLAG_BIT] = pres_raw_r;
        end else if (reg_addr_in == evt_irq_pkg::ADDR_PRES_ST) begin
            rdata_nxt[evt_irq_pkg::FLAG_BIT] = pres_st;
        end else if (reg_addr_in == evt_irq_pkg::ADDR_PRES_MASK_A) begin
            rdata_nxt[evt_irq_pkg::FLAG_BIT] = pres_mask_a_r;
        end else if (reg_addr_in == evt_irq_pkg::ADDR_PRES_MASK_B) begin
            rdata_nxt[evt_irq_pkg::FLAG_BIT] = pres_mask_b_r;
        end else if (reg_addr_in == evt_irq_pkg::ADDR_CHG_RAW) begin
            rdata_nxt[evt_irq_pkg::FLAG_BIT] = chg_raw_r;
        end else if (reg_addr_in == evt_irq_pkg::ADDR_CHG_ST) begin
            rdata_nxt[evt_irq_pkg::FLAG_BIT] = chg_st;
        end else if (reg_addr_in == evt_irq_pkg::ADDR_CHG_MASK_A) begin
            rdata_nxt[evt_irq_pkg::FLAG_BIT] = chg_mask_a_r;
        end else if (reg_addr_in == evt_irq_pkg::ADDR_CHG_MASK_B) begin
            rdata_nxt[evt_irq_pkg::FLAG_BIT] = chg_mask_b_r;
        end else if (reg_addr_in == evt_irq_pkg::ADDR_PIN_A_CFG) begin
            rdata_nxt[evt_irq_pkg::LEN_HI:evt_irq_pkg::LEN_LO] = len_a_r;
        end else if (reg_addr_in == evt_irq_pkg::ADDR_PIN_B_CFG) begin
            rdata_nxt[evt_irq_pkg::LEN_HI:evt_irq_pkg::LEN_LO] = len_b_r;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            pres_mask_a_r <= 1'b0;
            pres_mask_b_r <= 1'b0;
            chg_mask_a_r <= 1'b0;
            chg_mask_b_r <= 1'b0;
            len_a_r <= evt_irq_pkg::LEN_RESET;
            len_b_r <= evt_irq_pkg::LEN_RESET;
            rdata_r <= evt_irq_pkg::RDATA_IDLE;
        end else begin
            pres_mask_a_r <= pres_mask_a_nxt;
            pres_mask_b_r <= pres_mask_b_nxt;
            chg_mask_a_r <= chg_mask_a_nxt;
            chg_mask_b_r <= chg_mask_b_nxt;
            len_a_r <= len_a_nxt;
            len_b_r <= len_b_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_out = rdata_r;

    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    // no infoframe, no drop cause and no clear: only the vsync count may move raw
    assign pres_quiet = !frame_rx_in && !pkt_reset_in &&
        !pkt_type_wr_in && !pres_clr;

    sequence s_chg_held;
        frame_new_in ##1 (!chg_clr) [*2];
    endsequence

    a_pres_set: assert property (
        frame_rx_in |=> pres_raw_r)
        else $error("presence raw not set on infoframe");
    a_pres_timeout: assert property (
        vs_edge && pres_raw_r && vs_cnt_r == evt_irq_pkg::VSYNC_LIMIT
        && !frame_rx_in |=> !pres_raw_r)
        else $error("presence raw kept past vsync limit");
    a_pres_early: assert property (
        vs_edge && vs_cnt_r != evt_irq_pkg::VSYNC_LIMIT && pres_quiet
        |=> pres_raw_r == $past(pres_raw_r))
        else $error("presence raw dropped early");
    a_pres_drop: assert property (
        (pkt_reset_in || pkt_type_wr_in) && !frame_rx_in |=> !pres_raw_r)
        else $error("presence raw kept after packet reset");
    a_pres_level: assert property (
        !vs_edge && pres_quiet |=> $stable(pres_raw_r))
        else $error("presence raw changed with no cause");
    a_chg_latch: assert property (
        s_chg_held |=> chg_raw_r)
        else $error("changed raw not latched");
    a_pres_clear: assert property (
        pres_clr && !frame_rx_in && !pres_chg |=> !pres_raw_r && !pres_st)
        else $error("presence clear left raw or status");
    a_chg_clear: assert property (
        chg_clr && !frame_new_in |=> !chg_raw_r && !chg_st)
        else $error("changed clear left raw or status");
    a_set_wins: assert property (
        pres_clr && pres_chg && (pres_mask_a_r || pres_mask_b_r)
        |=> pres_st)
        else $error("event lost against clear");
    a_reset_masks: assert property (
        $rose(rst_n_in) |-> !pres_mask_a_r && !pres_mask_b_r
        && !chg_mask_a_r && !chg_mask_b_r)
        else $error("mask not off after reset");
    a_mask_route: assert property (
        $rose(irq_pin_a_out) |-> $past(agg_a))
        else $error("pin a raised with no routed status");
    a_chg_set_wins: assert property (
        chg_clr && frame_new_in && (chg_mask_a_r || chg_mask_b_r)
        |=> chg_st && chg_raw_r)
        else $error("changed event lost against clear");
    a_pin_b_route: assert property (
        $rose(irq_pin_b_out) |-> $past(agg_b))
        else $error("pin b raised with no routed status");
    a_hold_pin: assert property (
        len_a_r == evt_irq_pkg::LEN_HOLD && irq_pin_a_out && agg_a
        |=> irq_pin_a_out)
        else $error("pin a dropped in hold mode");
endmodule
`default_nettype wire

// ===== rtl/irq_pin_pulse.sv
// timed drive of one interrupt pin from its aggregate request
`timescale 1ns/1ps
`default_nettype none
module irq_pin_pulse (
    input wire logic mclk_in,          // crystal clock
    input wire logic rst_n_in,         // sync reset, active low
    input wire logic agg_in,           // any routed status set
    input wire logic [1:0] len_sel_in, // active length select
    output logic pin_out               // interrupt, active high
);
    evt_irq_pkg::pin_state_t state_r;
    evt_irq_pkg::pin_state_t state_nxt;
    logic [evt_irq_pkg::LEN_CNT_W-1:0] cnt_r;
    logic [evt_irq_pkg::LEN_CNT_W-1:0] cnt_nxt;
    logic [evt_irq_pkg::LEN_CNT_W-1:0] last;
    logic pin_r;
    logic pin_nxt;

    always_comb begin
        last = evt_irq_pkg::LEN_CNT_W'(evt_irq_pkg::LEN_4_CYC - 1);
        if (len_sel_in == evt_irq_pkg::LEN_16) begin
            last = evt_irq_pkg::LEN_CNT_W'(evt_irq_pkg::LEN_16_CYC - 1);
        end else if (len_sel_in == evt_irq_pkg::LEN_64) begin
            last = evt_irq_pkg::LEN_CNT_W'(evt_irq_pkg::LEN_64_CYC - 1);
        end
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            evt_irq_pkg::PIN_IDLE: begin
                cnt_nxt = '0;
                if (agg_in) begin
                    state_nxt = evt_irq_pkg::PIN_ACTIVE;
                end
            end
            evt_irq_pkg::PIN_ACTIVE: begin
                cnt_nxt = cnt_r + 1'b1;
                if (len_sel_in == evt_irq_pkg::LEN_HOLD) begin
                    if (!agg_in) begin
                        state_nxt = evt_irq_pkg::PIN_IDLE;
                    end
                end else if (cnt_r >= last) begin
                    state_nxt = evt_irq_pkg::PIN_DONE;
                end
            end
            evt_irq_pkg::PIN_DONE: begin
                // rearm only once all routed status is cleared or masked
                if (!agg_in) begin
                    state_nxt = evt_irq_pkg::PIN_IDLE;
                end
            end
            default: begin
                state_nxt = evt_irq_pkg::PIN_IDLE;
            end
        endcase
        pin_nxt = (state_nxt == evt_irq_pkg::PIN_ACTIVE);
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            state_r <= evt_irq_pkg::PIN_IDLE;
            cnt_r <= '0;
            pin_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pin_r <= pin_nxt;
        end
    end

    assign pin_out = pin_r;

    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_len4_pulse;
        pin_r [*4] ##1 !pin_r;
    endsequence
    a_pulse_len4: assert property (
        $rose(pin_r) && len_sel_in == evt_irq_pkg::LEN_4 |-> s_len4_pulse)
        else $error("pin pulse not four periods");
    a_no_repulse: assert property (
        state_r == evt_irq_pkg::PIN_DONE && agg_in |=> !pin_r)
        else $error("second pulse before clear");
    a_pin_follows: assert property (
        state_r == evt_irq_pkg::PIN_IDLE && agg_in |=> pin_r)
        else $error("pin missed routed event");
endmodule
`default_nettype wire
